//--- core/qcc_mpi_top.sv
/*
  command decoder of a four-channel codec: serial byte port, channel
  activation, resets, time slots, highways and the global clock-slot byte.
  assumes serial clock, select, data and frame sync arrive asynchronously
  and are much slower than sys_clk_i; channel enables and signaling mode
  come from the configuration logic as plain levels.
*/
`timescale 1ns/10ps
`include "qcc_regs.svh"
module qcc_mpi_top #(
  parameter logic HAS_HIGHWAY_B = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic serial_data_clock_i,
  input wire logic host_cs_n_i,
  input wire logic serial_data_io_i,
  output logic serial_data_io_o,
  output logic serial_data_io_oe_o,
  input wire logic frame_sync_i,
  input wire logic [3:0] chan_enable_i,
  input wire logic highway_signaling_mode_i,
  output logic [3:0] channel_active_flag_o,
  output logic [3:0] pcm_sample_valid_o,
  output logic [3:0] pcm_rx_enable_o,
  output logic [3:0] tx_hwy_a_drive_o,
  output logic [3:0] tx_hwy_b_drive_o,
  output logic [3:0] rx_highway_sel_o,
  output logic [27:0] tx_time_slot_o,
  output logic [27:0] rx_time_slot_o,
  output logic tx_edge_sel_o,
  output logic [2:0] tx_clock_slot_o,
  output logic [2:0] rx_clock_slot_o,
  output logic [3:0] chan_soft_reset_o,
  output logic hw_reset_o
);

  ////////////////////////////////////////////////////////////////////////
  // lowest enabled channel, used to pick the channel for slot reads
  function automatic logic [1:0] qcc_first_ch(input logic [3:0] en);
    logic [1:0] ch;
    ch = 2'h0;
    if (en[0]) begin
      ch = 2'h0;
    end else if (en[1]) begin
      ch = 2'h1;
    end else if (en[2]) begin
      ch = 2'h2;
    end else if (en[3]) begin
      ch = 2'h3;
    end
    return ch;
  endfunction

  qcc_mem_if mif ();

  qcc_slot_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .m(mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit0 clock, bit1 select, bit2 data, bit3 frame
  logic [3:0] pin_in;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] filt_reg;
  logic [3:0] prev_reg;

  assign pin_in = {frame_sync_i, serial_data_io_i, host_cs_n_i,
                   serial_data_clock_i};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= `QCC_PIN_RST;
      s2_reg <= `QCC_PIN_RST;
      s3_reg <= `QCC_PIN_RST;
      filt_reg <= `QCC_PIN_RST;
      prev_reg <= `QCC_PIN_RST;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a level counts only once two stages agree
      filt_reg <= ((s2_reg ~^ s3_reg) & s3_reg) |
                  ((s2_reg ^ s3_reg) & filt_reg);
      prev_reg <= filt_reg;
    end
  end

  logic serial_data_clock_rise;
  logic serial_data_clock_fall;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic fs_rise;

  assign serial_data_clock_rise = filt_reg[0] & ~prev_reg[0];
  assign serial_data_clock_fall = ~filt_reg[0] & prev_reg[0];
  assign cs_low = ~filt_reg[1];
  assign cs_fall = prev_reg[1] & ~filt_reg[1];
  assign cs_rise = ~prev_reg[1] & filt_reg[1];
  assign fs_rise = filt_reg[3] & ~prev_reg[3];

  ////////////////////////////////////////////////////////////////////////
  // byte framing
  logic [4:0] edge_cnt_reg;
  qcc_pkg::qcc_byte_t in_sh_reg;
  logic byte_done;
  logic frame_reset;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      edge_cnt_reg <= 5'h00;
    end else if (cs_low && serial_data_clock_rise &&
                 edge_cnt_reg < `QCC_RST_EDGES) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_sh_reg <= 8'h00;
    end else if (cs_low && serial_data_clock_rise) begin
      in_sh_reg <= {in_sh_reg[6:0], filt_reg[2]};
    end
  end

  assign byte_done = cs_rise && edge_cnt_reg >= `QCC_MIN_EDGES &&
                     edge_cnt_reg < `QCC_RST_EDGES;
  assign frame_reset = cs_rise && edge_cnt_reg >= `QCC_RST_EDGES;

  ////////////////////////////////////////////////////////////////////////
  // command sequencing
  qcc_pkg::qcc_state_t state_reg;
  qcc_pkg::qcc_byte_t cmd_reg;
  qcc_pkg::qcc_byte_t clk_reg;
  logic [3:0] act_reg;
  logic hw_rst_reg;
  logic [3:0] sw_rst_reg;
  logic any_en;
  logic [3:0] act_set;
  logic [3:0] act_clr;
  logic hw_req;
  logic [3:0] sw_req;
  logic slot_wr;
  logic clk_wr;

  assign any_en = |chan_enable_i;

  always_comb begin
    act_set = 4'h0;
    act_clr = 4'h0;
    hw_req = frame_reset;
    sw_req = 4'h0;
    if (byte_done && state_reg == qcc_pkg::st_cmd) begin
      unique case (in_sh_reg)
        `QCC_OP_DEACT: act_clr = chan_enable_i;
        `QCC_OP_SWRST: sw_req = chan_enable_i;
        `QCC_OP_HWRST: hw_req = 1'b1;
        `QCC_OP_ACT: act_set = chan_enable_i;
        default: act_set = 4'h0;
      endcase
    end
  end

  assign slot_wr = byte_done && state_reg == qcc_pkg::st_wdata &&
                   (cmd_reg == `QCC_OP_TXS_WR ||
                    cmd_reg == `QCC_OP_RXS_WR);
  assign clk_wr = byte_done && state_reg == qcc_pkg::st_wdata &&
                  cmd_reg == `QCC_OP_CLK_WR && any_en;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= qcc_pkg::st_cmd;
      cmd_reg <= `QCC_OP_NOP;
    end else if (hw_rst_reg) begin
      state_reg <= qcc_pkg::st_cmd;
      cmd_reg <= `QCC_OP_NOP;
    end else if (byte_done) begin
      unique case (state_reg)
        qcc_pkg::st_cmd: begin
          cmd_reg <= in_sh_reg;
          // unlisted codes fall through as no-ops
          if (in_sh_reg == `QCC_OP_TXS_WR ||
              in_sh_reg == `QCC_OP_RXS_WR ||
              in_sh_reg == `QCC_OP_CLK_WR) begin
            state_reg <= qcc_pkg::st_wdata;
          end else if (in_sh_reg == `QCC_OP_TXS_RD ||
                       in_sh_reg == `QCC_OP_RXS_RD ||
                       in_sh_reg == `QCC_OP_CLK_RD) begin
            state_reg <= qcc_pkg::st_rdata;
          end
        end
        qcc_pkg::st_wdata: state_reg <= qcc_pkg::st_cmd;
        qcc_pkg::st_rdata: state_reg <= qcc_pkg::st_cmd;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hw_rst_reg <= 1'b0;
      sw_rst_reg <= 4'h0;
    end else begin
      hw_rst_reg <= hw_req;
      sw_rst_reg <= sw_req;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_reg <= 4'h0;
    end else if (hw_rst_reg) begin
      act_reg <= 4'h0;
    end else begin
      act_reg <= (act_reg & ~act_clr & ~sw_req) | act_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_reg <= `QCC_CLK_RST;
    end else if (hw_rst_reg) begin
      clk_reg <= `QCC_CLK_RST;
    end else if (clk_wr) begin
      clk_reg <= in_sh_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slot store access
  // writes to every enabled, reads lowest
  assign mif.clear = hw_rst_reg;
  assign mif.wr_mask = slot_wr ? chan_enable_i : 4'h0;
  assign mif.wr_rx = cmd_reg[1];
  assign mif.wr_data = in_sh_reg;
  assign mif.rd_ch = qcc_first_ch(chan_enable_i);
  assign mif.rd_rx = cmd_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // read-back shifter; data changes on falling serial clock
  qcc_pkg::qcc_byte_t out_sh_reg;
  qcc_pkg::qcc_byte_t rd_byte;
  logic oe_reg;

  always_comb begin
    if (!any_en) begin
      rd_byte = 8'h00;
    end else if (cmd_reg == `QCC_OP_CLK_RD) begin
      rd_byte = clk_reg;
    end else begin
      rd_byte = mif.rd_data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_sh_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else if (state_reg != qcc_pkg::st_rdata || hw_rst_reg) begin
      out_sh_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else if (cs_fall) begin
      out_sh_reg <= rd_byte;
      oe_reg <= 1'b1;
    end else if (cs_rise) begin
      oe_reg <= 1'b0;
    end else if (cs_low && serial_data_clock_fall) begin
      out_sh_reg <= {out_sh_reg[6:0], 1'b0};
    end
  end

  assign serial_data_io_o = out_sh_reg[7];
  assign serial_data_io_oe_o = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // per-channel PCM steering
  logic [1:0] fs_cnt_reg [4];
  logic [3:0] valid_reg;
  logic [3:0] rx_en_reg;
  logic [3:0] hwy_a_reg;
  logic [3:0] hwy_b_reg;
  logic [3:0] rx_sel_reg;
  logic port_b;

  assign port_b = HAS_HIGHWAY_B;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      logic drive;
      logic tsel;
      assign drive = act_reg[g] | highway_signaling_mode_i;
      assign tsel = mif.tx_slot[g][`QCC_HWY_BIT];

      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          fs_cnt_reg[g] <= 2'h0;
        end else if (act_set[g] || !act_reg[g]) begin
          fs_cnt_reg[g] <= 2'h0;
        end else if (fs_rise && fs_cnt_reg[g] != `QCC_FS_WAIT) begin
          fs_cnt_reg[g] <= fs_cnt_reg[g] + 2'h1;
        end
      end

      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          valid_reg[g] <= 1'b0;
          rx_en_reg[g] <= 1'b0;
          hwy_a_reg[g] <= 1'b0;
          hwy_b_reg[g] <= 1'b0;
          rx_sel_reg[g] <= 1'b0;
        end else begin
          valid_reg[g] <= act_reg[g] && fs_cnt_reg[g] == `QCC_FS_WAIT;
          rx_en_reg[g] <= drive;
          hwy_a_reg[g] <= drive & (clk_reg[`QCC_TAB_BIT] | ~tsel);
          hwy_b_reg[g] <= drive & port_b &
                          (clk_reg[`QCC_TAB_BIT] | tsel);
          rx_sel_reg[g] <= port_b & mif.rx_slot[g][`QCC_HWY_BIT];
        end
      end

      assign tx_time_slot_o[7*g +: 7] = mif.tx_slot[g][6:0];
      assign rx_time_slot_o[7*g +: 7] = mif.rx_slot[g][6:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  assign channel_active_flag_o = act_reg;
  assign pcm_sample_valid_o = valid_reg;
  assign pcm_rx_enable_o = rx_en_reg;
  assign tx_hwy_a_drive_o = hwy_a_reg;
  assign tx_hwy_b_drive_o = hwy_b_reg;
  assign rx_highway_sel_o = rx_sel_reg;
  assign tx_edge_sel_o = clk_reg[`QCC_XE_BIT];
  assign rx_clock_slot_o = clk_reg[`QCC_RCS_MSB:`QCC_RCS_LSB];
  assign tx_clock_slot_o = clk_reg[`QCC_TCS_MSB:`QCC_TCS_LSB];
  assign chan_soft_reset_o = sw_rst_reg;
  assign hw_reset_o = hw_rst_reg;
endmodule

//--- core/qcc_regs.svh
/*
  command codes, field positions, reset values and counts of the quad codec
  command port. assumes inclusion by bare name from the decoder and the slot store.
*/
`ifndef QCC_REGS_SVH
`define QCC_REGS_SVH
`define QCC_OP_DEACT 8'h00
`define QCC_OP_SWRST 8'h02
`define QCC_OP_HWRST 8'h04
`define QCC_OP_NOP 8'h06
`define QCC_OP_ACT 8'h0e
`define QCC_OP_TXS_WR 8'h40
`define QCC_OP_TXS_RD 8'h41
`define QCC_OP_RXS_WR 8'h42
`define QCC_OP_RXS_RD 8'h43
`define QCC_OP_CLK_WR 8'h44
`define QCC_OP_CLK_RD 8'h45
`define QCC_HWY_BIT 7
`define QCC_TAB_BIT 7
`define QCC_XE_BIT 6
`define QCC_RCS_MSB 5
`define QCC_RCS_LSB 3
`define QCC_TCS_MSB 2
`define QCC_TCS_LSB 0
`define QCC_CLK_RST 8'h00
`define QCC_SLOT_RST_BASE 8'h00
`define QCC_MIN_EDGES 5'h08
`define QCC_RST_EDGES 5'h10
`define QCC_FS_WAIT 2'h2
`define QCC_PIN_RST 4'h3
`endif

//--- core/qcc_pkg.sv
/*
  types shared by the command decoder and its slot store.
  assumes nothing beyond a SystemVerilog compiler.
*/
package qcc_pkg;
  typedef logic [7:0] qcc_byte_t;
  typedef enum logic [1:0] {
    st_cmd,
    st_wdata,
    st_rdata
  } qcc_state_t;
endpackage

//--- core/qcc_mem_if.sv
/*
  link between the command decoder and the slot store.
  assumes both ends run on sys_clk_i.
*/
`timescale 1ns/10ps
interface qcc_mem_if;
  logic clear;
  logic [3:0] wr_mask;
  logic wr_rx;
  qcc_pkg::qcc_byte_t wr_data;
  logic [1:0] rd_ch;
  logic rd_rx;
  qcc_pkg::qcc_byte_t rd_data;
  qcc_pkg::qcc_byte_t tx_slot [4];
  qcc_pkg::qcc_byte_t rx_slot [4];
  modport ctrl (
    output clear, wr_mask, wr_rx, wr_data, rd_ch, rd_rx,
    input rd_data, tx_slot, rx_slot
  );
  modport mem (
    input clear, wr_mask, wr_rx, wr_data, rd_ch, rd_rx,
    output rd_data, tx_slot, rx_slot
  );
endinterface

//--- core/qcc_slot_mem.sv
/*
  per-channel transmit and receive slot bytes with a registered read port.
  assumes a synchronous clear from the decoder for the hard reset code.
*/
`timescale 1ns/10ps
`include "qcc_regs.svh"
module qcc_slot_mem (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  qcc_mem_if.mem m
);
  qcc_pkg::qcc_byte_t tx_reg [4];
  qcc_pkg::qcc_byte_t rx_reg [4];

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          tx_reg[g] <= 8'(`QCC_SLOT_RST_BASE + g);
          rx_reg[g] <= 8'(`QCC_SLOT_RST_BASE + g);
        end else if (m.clear) begin
          tx_reg[g] <= 8'(`QCC_SLOT_RST_BASE + g);
          rx_reg[g] <= 8'(`QCC_SLOT_RST_BASE + g);
        end else if (m.wr_mask[g]) begin
          if (m.wr_rx) begin
            rx_reg[g] <= m.wr_data;
          end else begin
            tx_reg[g] <= m.wr_data;
          end
        end
      end
      assign m.tx_slot[g] = tx_reg[g];
      assign m.rx_slot[g] = rx_reg[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m.rd_data <= 8'h00;
    end else begin
      m.rd_data <= m.rd_rx ? rx_reg[m.rd_ch] : tx_reg[m.rd_ch];
    end
  end
endmodule

//--- bench/qcc_mpi_asserts.sv
/* port assertions of the codec command decoder.
   assumes one clock domain and binding into qcc_mpi_top. */
`timescale 1ns/10ps
module qcc_mpi_asserts (
  input logic sys_clk_i,
  input logic resetn_i,
  input logic host_cs_n_i,
  input logic frame_sync_i,
  input logic [3:0] chan_enable_i,
  input logic highway_signaling_mode_i,
  input logic [3:0] channel_active_flag_o,
  input logic [3:0] pcm_sample_valid_o,
  input logic [3:0] pcm_rx_enable_o,
  input logic [3:0] tx_hwy_a_drive_o,
  input logic [3:0] tx_hwy_b_drive_o,
  input logic [27:0] tx_time_slot_o,
  input logic [27:0] rx_time_slot_o,
  input logic tx_edge_sel_o,
  input logic [2:0] tx_clock_slot_o,
  input logic [2:0] rx_clock_slot_o,
  input logic [3:0] chan_soft_reset_o,
  input logic hw_reset_o
);
  logic fs_q;
  logic [1:0] fs_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) fs_q <= 1'h0;
    else fs_q <= frame_sync_i;
  end
  // raw pin count, never behind the design's synchronised one
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) fs_cnt <= 2'h0;
    else if (!channel_active_flag_o[0]) fs_cnt <= 2'h0;
    else if (frame_sync_i && !fs_q && fs_cnt != 2'h3) fs_cnt <= fs_cnt + 2'h1;
  end
  ////////////////////
  property p_hw_once; hw_reset_o |=> !hw_reset_o; endproperty
  a_hw_once: assert property (p_hw_once)
    else $error("hard reset pulse too long");
  property p_hw_dflt;
    hw_reset_o |=> tx_time_slot_o == 28'h0608080 &&
      rx_time_slot_o == 28'h0608080 && !tx_edge_sel_o &&
      {rx_clock_slot_o, tx_clock_slot_o} == 6'h00 &&
      channel_active_flag_o == 4'h0;
  endproperty
  a_hw_dflt: assert property (p_hw_dflt)
    else $error("hard reset left wrong state");
  property p_soft_mask;
    |chan_soft_reset_o |-> (chan_soft_reset_o & ~chan_enable_i) == 4'h0
      ##1 chan_soft_reset_o == 4'h0;
  endproperty
  a_soft_mask: assert property (p_soft_mask)
    else $error("soft reset hit a disabled channel");
  property p_quiet;
    (channel_active_flag_o == 4'h0 && !highway_signaling_mode_i)[*3] |->
      pcm_rx_enable_o == 4'h0 && (tx_hwy_a_drive_o | tx_hwy_b_drive_o) == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("standby channel still on highway");
  property p_sig; highway_signaling_mode_i[*3] |-> pcm_rx_enable_o == 4'hf;
  endproperty
  a_sig: assert property (p_sig)
    else $error("signaling mode left pcm off");
  property p_valid_fs; $rose(pcm_sample_valid_o[0]) |-> fs_cnt >= 2'h2;
  endproperty
  a_valid_fs: assert property (p_valid_fs)
    else $error("samples valid before second frame sync");
  property p_valid_flag;
    (pcm_sample_valid_o & ~$past(channel_active_flag_o)) == 4'h0;
  endproperty
  a_valid_flag: assert property (p_valid_flag)
    else $error("valid samples on inactive channel");
  property p_frame_hold;
    (!host_cs_n_i)[*8] |-> $stable(tx_time_slot_o) &&
      $stable(rx_time_slot_o) && $stable(tx_edge_sel_o);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("settings changed inside a select low period");
  c_hw: cover property (hw_reset_o);
  c_soft: cover property (|chan_soft_reset_o);
  c_valid: cover property ($rose(pcm_sample_valid_o[0]));
endmodule
bind qcc_mpi_top qcc_mpi_asserts chk (.sys_clk_i, .resetn_i, .host_cs_n_i,
  .frame_sync_i, .chan_enable_i, .highway_signaling_mode_i,
  .channel_active_flag_o, .pcm_sample_valid_o, .pcm_rx_enable_o,
  .tx_hwy_a_drive_o, .tx_hwy_b_drive_o, .tx_time_slot_o, .rx_time_slot_o,
  .tx_edge_sel_o, .tx_clock_slot_o, .rx_clock_slot_o, .chan_soft_reset_o,
  .hw_reset_o);

//--- bench/qcc_host_model.sv
/* behavioural host framing bytes on the serial command port.
   assumes one caller of xfer at a time. */
`timescale 1ns/10ps
module qcc_host_model (
  input logic dio_o_i,
  input logic dio_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic dio_o
);
  logic d = 1'h0;
  logic drv = 1'h0;
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
  end
  // released line shows the inverse bit, so a stale copy never passes
  assign dio_o = dio_oe_i ? dio_o_i : (drv ? d : ~d);
  ////////////////////
  // msb first, select high between bytes
  task automatic xfer(input logic [7:0] b, input int n, input logic rd,
    output logic [7:0] q);
    q = 8'h00;
    #7;
    cs_n_o = 1'h0;
    drv = !rd;
    #200;
    for (int k = n - 1; k >= 0; k--) begin
      if (!rd) d = (k < 8) ? b[k] : 1'h0;
      #100;
      sclk_o = 1'h1;
      #100;
      q = {q[6:0], dio_o};
      sclk_o = 1'h0;
    end
    cs_n_o = 1'h1;
    drv = 1'h0;
    #600;
  endtask
endmodule

//--- bench/tb_quad_codec_mpi_channel_control.sv
/* self-checking bench of the command decoder.
   assumes the host model and the bound checker. */
`timescale 1ns/10ps
module tb_quad_codec_mpi_channel_control;
  logic sys_clk_i, resetn_i, frame_sync_i, highway_signaling_mode_i;
  logic [3:0] chan_enable_i, m;
  wire serial_data_clock_i, host_cs_n_i, serial_data_io_i;
  wire serial_data_io_o, serial_data_io_oe_o, tx_edge_sel_o, hw_reset_o;
  wire [3:0] channel_active_flag_o, pcm_sample_valid_o, pcm_rx_enable_o;
  wire [3:0] tx_hwy_a_drive_o, tx_hwy_b_drive_o, rx_highway_sel_o;
  wire [3:0] chan_soft_reset_o;
  wire [27:0] tx_time_slot_o, rx_time_slot_o;
  wire [2:0] tx_clock_slot_o, rx_clock_slot_o;
  logic [7:0] tx [4];
  logic [7:0] rx [4];
  logic [7:0] ck, q, op;
  logic [31:0] seed, v;
  int miscompares, tests_run, j;
  qcc_mpi_top uut (.sys_clk_i, .resetn_i, .serial_data_clock_i,
    .host_cs_n_i, .serial_data_io_i, .serial_data_io_o,
    .serial_data_io_oe_o, .frame_sync_i, .chan_enable_i,
    .highway_signaling_mode_i, .channel_active_flag_o, .pcm_sample_valid_o,
    .pcm_rx_enable_o, .tx_hwy_a_drive_o, .tx_hwy_b_drive_o,
    .rx_highway_sel_o, .tx_time_slot_o, .rx_time_slot_o, .tx_edge_sel_o,
    .tx_clock_slot_o, .rx_clock_slot_o, .chan_soft_reset_o, .hw_reset_o);
  qcc_host_model host (.dio_o_i(serial_data_io_o),
    .dio_oe_i(serial_data_io_oe_o), .sclk_o(serial_data_clock_i),
    .cs_n_o(host_cs_n_i), .dio_o(serial_data_io_i));
  initial begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [27:0] pk(input logic [7:0] a [4]);
    for (int i = 0; i < 4; i++) pk[7*i +: 7] = a[i][6:0];
  endfunction
  function automatic logic [3:0] hw(input logic [7:0] a [4]);
    for (int i = 0; i < 4; i++) hw[i] = a[i][7];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st();
    chk("tx slots", pk(tx), tx_time_slot_o);
    chk("rx slots", pk(rx), rx_time_slot_o);
    chk("rx hwy", hw(rx), rx_highway_sel_o);
    chk("clk", ck[6:0], {tx_edge_sel_o, rx_clock_slot_o, tx_clock_slot_o});
  endtask
  task automatic dchk(input logic [3:0] a);
    chk("hwy a", a & (~hw(tx) | {4{ck[7]}}), tx_hwy_a_drive_o);
    chk("hwy b", a & (hw(tx) | {4{ck[7]}}), tx_hwy_b_drive_o);
  endtask
  task automatic dflt();
    for (int i = 0; i < 4; i++) begin
      tx[i] = 8'(i);
      rx[i] = 8'(i);
    end
    ck = 8'h00;
  endtask
  task automatic setn(input logic [3:0] e);
    @(posedge sys_clk_i);
    chan_enable_i <= e;
    @(posedge sys_clk_i);
  endtask
  task automatic cmd(input logic [7:0] o);
    host.xfer(o, 8, 1'h0, q);
  endtask
  task automatic wr(input logic [7:0] o, d);
    cmd(o);
    host.xfer(d, 8, 1'h0, q);
  endtask
  task automatic rd(input logic [7:0] o);
    cmd(o);
    host.xfer(8'h00, 8, 1'h1, q);
  endtask
  task automatic fsp();
    @(posedge sys_clk_i);
    frame_sync_i <= 1'h1;
    repeat (8) @(posedge sys_clk_i);
    frame_sync_i <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////
  initial begin
    seed = 32'h622d2bd9;
    miscompares = 0;
    tests_run = 0;
    resetn_i = 1'h0;
    frame_sync_i = 1'h0;
    highway_signaling_mode_i = 1'h0;
    chan_enable_i = 4'hf;
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    repeat (6) @(posedge sys_clk_i);
    dflt();
    st();
    for (int k = 0; k < 6; k++) begin
      v = rnd();
      m = (v[3:0] == 4'h0) ? 4'h8 : v[3:0];
      op = v[4] ? 8'h42 : 8'h40;
      setn(m);
      wr(op, v[15:8]);
      for (int i = 0; i < 4; i++) begin
        if (m[i] && v[4]) rx[i] = v[15:8];
        if (m[i] && !v[4]) tx[i] = v[15:8];
      end
      st();
      m = (v[19:16] == 4'h0) ? 4'h2 : v[19:16];
      for (int i = 3; i >= 0; i--) if (m[i]) j = i;
      setn(m);
      rd(op | 8'h01);
      chk("slot read", v[4] ? rx[j] : tx[j], q);
    end
    $display("slot test done");
    v = rnd();
    setn(4'h0);
    wr(8'h44, v[7:0]);
    st();
    rd(8'h45);
    chk("clock read off", 8'h00, q);
    setn(4'hf);
    wr(8'h44, v[7:0]);
    ck = v[7:0];
    st();
    rd(8'h45);
    chk("clock read", ck, q);
    $display("clock test done");
    setn(4'h1);
    wr(8'h40, 8'h85);
    tx[0] = 8'h85;
    wr(8'h44, 8'h00);
    ck = 8'h00;
    cmd(8'h0e);
    chk("active", 4'h1, channel_active_flag_o);
    fsp();
    chk("valid early", 4'h0, pcm_sample_valid_o);
    fsp();
    chk("valid", 4'h1, pcm_sample_valid_o);
    dchk(4'h1);
    wr(8'h44, 8'h80);
    ck = 8'h80;
    dchk(4'h1);
    wr(8'h40, 8'h05);
    tx[0] = 8'h05;
    dchk(4'h1);
    wr(8'h44, 8'h7d);
    ck = 8'h7d;
    dchk(4'h1);
    cmd(8'h02);
    chk("soft reset", 4'h0, channel_active_flag_o);
    st();
    cmd(8'h0e);
    cmd(8'h06);
    chk("idle code", 4'h1, channel_active_flag_o);
    st();
    cmd(8'h00);
    chk("standby", 4'h0, channel_active_flag_o);
    st();
    chk("pcm off", 4'h0, pcm_rx_enable_o);
    @(posedge sys_clk_i);
    highway_signaling_mode_i <= 1'h1;
    repeat (5) @(posedge sys_clk_i);
    chk("pcm signaling", 4'hf, pcm_rx_enable_o);
    highway_signaling_mode_i <= 1'h0;
    $display("mode test done");
    host.xfer(8'h0e, 5, 1'h0, q);
    chk("short frame", 4'h0, channel_active_flag_o);
    host.xfer(8'h0e, 10, 1'h0, q);
    chk("long frame", 4'h1, channel_active_flag_o);
    host.xfer(8'h0e, 16, 1'h0, q);
    dflt();
    st();
    chk("reset flags", 4'h0, channel_active_flag_o);
    setn(4'hf);
    wr(8'h42, 8'h9a);
    for (int i = 0; i < 4; i++) rx[i] = 8'h9a;
    wr(8'h44, 8'hff);
    ck = 8'hff;
    st();
    setn(4'h0);
    cmd(8'h04);
    dflt();
    st();
    $display("reset test done");
    test_done();
  end
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    miscompares++;
    test_done();
  end
endmodule
